// ---- rtl/lpsdr_params.svh ----
// Purpose: shared constants for the low-power sdram command model
// Assumes: 10 MHz design clock
// Notes: tRP, tRFC and tXS counts derived from times in ns, the exit wait from us, the rest given in cycles
`ifndef LPSDR_PARAMS_SVH
`define LPSDR_PARAMS_SVH
`define LPSDR_CLK_NS 100
`define LPSDR_TRP_NS 30
`define LPSDR_TRP_CYC ((`LPSDR_TRP_NS + `LPSDR_CLK_NS - 1) / `LPSDR_CLK_NS)
`define LPSDR_TRFC_NS 110
`define LPSDR_TRFC_CYC ((`LPSDR_TRFC_NS + `LPSDR_CLK_NS - 1) / `LPSDR_CLK_NS)
`define LPSDR_TXS_NS 120
`define LPSDR_TXS_CYC ((`LPSDR_TXS_NS + `LPSDR_CLK_NS - 1) / `LPSDR_CLK_NS)
`define LPSDR_TXP_CYC 2
`define LPSDR_TCKE_CYC 2
`define LPSDR_TWR_CYC 2
`define LPSDR_DPD_EXIT_US 200
`define LPSDR_DPD_EXIT_CYC ((`LPSDR_DPD_EXIT_US * 1000) / `LPSDR_CLK_NS)
`define LPSDR_REFI_CYC 78
`define LPSDR_A10 10
`endif

// ---- rtl/lpsdr_pkg.sv ----
// Purpose: types for the low-power sdram command model
// Assumes: four banks
// Notes: command encodings follow cs,ras,cas,we order
package lpsdr_pkg;
  typedef enum logic [3:0] {
    LPSDR_CMD_DESEL = 4'h8,
    LPSDR_CMD_NOP   = 4'h7,
    LPSDR_CMD_ACT   = 4'h3,
    LPSDR_CMD_RD    = 4'h5,
    LPSDR_CMD_WR    = 4'h4,
    LPSDR_CMD_BST   = 4'h6,
    LPSDR_CMD_PRE   = 4'h2,
    LPSDR_CMD_REF   = 4'h1,
    LPSDR_CMD_MRS   = 4'h0
  } lpsdr_cmd_t;
  typedef enum logic [1:0] {LPSDR_BK_IDLE, LPSDR_BK_ACTIVE, LPSDR_BK_PRECH} lpsdr_bank_t;
  typedef enum logic [2:0] {
    LPSDR_M_NORMAL, LPSDR_M_SELF_REF, LPSDR_M_PD_PRE, LPSDR_M_PD_ACT, LPSDR_M_DEEP
  } lpsdr_mode_t;
endpackage

// ---- rtl/lpsdr_if.sv ----
// Purpose: command link between controller and device
// Assumes: one clock, command on each edge
// Notes: data pairs modelled as single words with mask
`timescale 1ns/100ps
interface lpsdr_if #(parameter int AW = 13, parameter int DW = 16);
  logic cke;
  logic [3:0] cmd;
  logic [AW-1:0] addr;
  logic [1:0] ba;
  logic [DW-1:0] wdata;
  logic dm;
  logic [DW-1:0] rdata;
  logic rvalid;
  modport ctrl (output cke, cmd, addr, ba, wdata, dm, input rdata, rvalid);
  modport dev (input cke, cmd, addr, ba, wdata, dm, output rdata, rvalid);
endinterface

// ---- rtl/lpsdr_bank.sv ----
// Purpose: one bank state tracker with precharge timer
// Assumes: commands decoded by the owning device
// Notes: precharge ignored unless row active
`timescale 1ns/100ps
`include "lpsdr_params.svh"
module lpsdr_bank #(parameter int BL = 4) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // decoded strobes
  input wire logic act_i,
  input wire logic pre_i,
  input wire logic acc_i,
  input wire logic ap_i,
  input wire logic lose_i,
  // state
  output lpsdr_pkg::lpsdr_bank_t state_o
);
  lpsdr_pkg::lpsdr_bank_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic ap_reg, ap_next;
  assign state_o = state_reg;
  // bank state next value
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    ap_next = ap_reg;
    if (lose_i) begin
      state_next = lpsdr_pkg::LPSDR_BK_IDLE;
      ap_next = 1'b0;
    end else begin
      unique case (state_reg)
        lpsdr_pkg::LPSDR_BK_IDLE: begin
          if (act_i) begin
            state_next = lpsdr_pkg::LPSDR_BK_ACTIVE;
          end
        end
        lpsdr_pkg::LPSDR_BK_ACTIVE: begin
          if (cnt_reg != 4'h0) begin
            cnt_next = cnt_reg - 4'h1;
          end
          if (pre_i) begin
            state_next = lpsdr_pkg::LPSDR_BK_PRECH;
            cnt_next = 4'(`LPSDR_TRP_CYC);
            ap_next = 1'b0;
          end else if (acc_i) begin
            ap_next = ap_i;
            cnt_next = 4'(BL / 2);
          end else if (ap_reg && cnt_reg == 4'h1) begin
            state_next = lpsdr_pkg::LPSDR_BK_PRECH;
            cnt_next = 4'(`LPSDR_TRP_CYC);
            ap_next = 1'b0;
          end
        end
        lpsdr_pkg::LPSDR_BK_PRECH: begin
          if (cnt_reg <= 4'h1) begin
            state_next = lpsdr_pkg::LPSDR_BK_IDLE;
            cnt_next = 4'h0;
          end else begin
            cnt_next = cnt_reg - 4'h1;
          end
        end
        default: state_next = lpsdr_pkg::LPSDR_BK_IDLE;
      endcase
    end
  end
  // bank state registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= lpsdr_pkg::LPSDR_BK_IDLE;
      cnt_reg <= 4'h0;
      ap_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ap_reg <= ap_next;
    end
  end
endmodule // lpsdr_bank

// ---- rtl/lpsdr_dev.sv ----
// Purpose: device end: bank tracking, refresh, low-power modes
// Assumes: dev samples cke and command each clk_i edge
// Notes: array modelled as small word store per bank
`timescale 1ns/100ps
`include "lpsdr_params.svh"
module lpsdr_dev #(
  parameter int AW = 13,
  parameter int DW = 16,
  parameter int BL = 4,
  parameter int RAW = 13,
  parameter int MW = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // link
  lpsdr_if.dev link,
  // status
  output lpsdr_pkg::lpsdr_mode_t mode_o,
  output logic [RAW-1:0] ref_row_o,
  output logic [3:0] bank_active_o,
  output logic need_init_o
);
  localparam int NB = 4;
  lpsdr_pkg::lpsdr_cmd_t cmd;
  lpsdr_pkg::lpsdr_bank_t bank_st [NB];
  lpsdr_pkg::lpsdr_mode_t mode_reg, mode_next;
  logic [RAW-1:0] row_reg, row_next;
  logic [7:0] sref_cnt_reg, sref_cnt_next;
  logic init_reg, init_next;
  logic [3:0] act_reg, act_next;
  logic [1:0] wr_bank_reg, wr_bank_next;
  logic [3:0] wr_left_reg, wr_left_next;
  logic [MW-1:0] wr_col_reg, wr_col_next;
  logic [DW-1:0] mem [NB][2**MW];
  logic [DW-1:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [NB-1:0] act_s, pre_s, acc_s;
  logic live, any_open, wr_trunc, wr_en;

  // decodes a bank-targeted strobe from bank select and a10
  function automatic logic [NB-1:0] lpsdr_sel(input logic [1:0] ba, input logic all);
    lpsdr_sel = all ? 4'hF : (4'h1 << ba);
  endfunction

  assign cmd = lpsdr_pkg::lpsdr_cmd_t'(link.cmd);
  assign mode_o = mode_reg;
  assign ref_row_o = row_reg;
  assign bank_active_o = act_reg;
  assign need_init_o = init_reg;
  assign link.rdata = rdata_reg;
  assign link.rvalid = rvalid_reg;
  // commands count only in normal mode with cke high
  assign live = (mode_reg == lpsdr_pkg::LPSDR_M_NORMAL) && link.cke;
  assign act_s = (live && cmd == lpsdr_pkg::LPSDR_CMD_ACT) ? lpsdr_sel(link.ba, 1'b0) : 4'h0;
  assign pre_s = (live && cmd == lpsdr_pkg::LPSDR_CMD_PRE) ?
                 lpsdr_sel(link.ba, link.addr[`LPSDR_A10]) : 4'h0;
  assign acc_s = (live && (cmd == lpsdr_pkg::LPSDR_CMD_RD || cmd == lpsdr_pkg::LPSDR_CMD_WR)) ?
                 lpsdr_sel(link.ba, 1'b0) : 4'h0;
  assign wr_trunc = pre_s[wr_bank_reg];
  assign wr_en = (wr_left_reg != 4'h0) && !wr_trunc && !link.dm;

  // one tracker per bank
  for (genvar b = 0; b < NB; b++) begin : g_bank
    lpsdr_bank #(.BL(BL)) u_bank (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .act_i(act_s[b]),
      .pre_i(pre_s[b]),
      .acc_i(acc_s[b]),
      .ap_i(link.addr[`LPSDR_A10]),
      .lose_i(mode_reg == lpsdr_pkg::LPSDR_M_DEEP),
      .state_o(bank_st[b])
    );
  end

  // mode, refresh and data next values
  always_comb begin
    mode_next = mode_reg;
    row_next = row_reg;
    sref_cnt_next = sref_cnt_reg;
    init_next = init_reg;
    wr_bank_next = wr_bank_reg;
    wr_left_next = wr_left_reg;
    wr_col_next = wr_col_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    any_open = 1'b0;
    for (int b = 0; b < NB; b++) begin
      act_next[b] = (bank_st[b] == lpsdr_pkg::LPSDR_BK_ACTIVE);
      any_open = any_open | act_next[b];
    end
    if (wr_left_reg != 4'h0) begin
      wr_left_next = wr_trunc ? 4'h0 : wr_left_reg - 4'h1;
      wr_col_next = wr_col_reg + 1'b1;
    end
    unique case (mode_reg)
      lpsdr_pkg::LPSDR_M_NORMAL: begin
        if (!link.cke) begin
          if (cmd == lpsdr_pkg::LPSDR_CMD_REF) begin
            mode_next = lpsdr_pkg::LPSDR_M_SELF_REF;
            sref_cnt_next = 8'h0;
          end else if (cmd == lpsdr_pkg::LPSDR_CMD_BST && !any_open) begin
            mode_next = lpsdr_pkg::LPSDR_M_DEEP;
            init_next = 1'b1;
          end else if (wr_left_reg == 4'h0) begin
            mode_next = any_open ? lpsdr_pkg::LPSDR_M_PD_ACT : lpsdr_pkg::LPSDR_M_PD_PRE;
          end
        end else if (cmd == lpsdr_pkg::LPSDR_CMD_REF) begin
          row_next = row_reg + 1'b1;
        end else if (cmd == lpsdr_pkg::LPSDR_CMD_MRS) begin
          init_next = 1'b0;
        end else if (cmd == lpsdr_pkg::LPSDR_CMD_WR && bank_st[link.ba] == lpsdr_pkg::LPSDR_BK_ACTIVE) begin
          wr_bank_next = link.ba;
          wr_left_next = 4'(BL);
          wr_col_next = link.addr[MW-1:0];
        end else if (cmd == lpsdr_pkg::LPSDR_CMD_RD && bank_st[link.ba] == lpsdr_pkg::LPSDR_BK_ACTIVE) begin
          rdata_next = mem[link.ba][link.addr[MW-1:0]];
          rvalid_next = 1'b1;
        end
      end
      lpsdr_pkg::LPSDR_M_SELF_REF: begin
        sref_cnt_next = sref_cnt_reg + 8'h1;
        if (sref_cnt_reg == 8'(`LPSDR_REFI_CYC)) begin
          row_next = row_reg + 1'b1;
          sref_cnt_next = 8'h0;
        end
        if (link.cke) begin
          mode_next = lpsdr_pkg::LPSDR_M_NORMAL;
        end
      end
      lpsdr_pkg::LPSDR_M_PD_PRE, lpsdr_pkg::LPSDR_M_PD_ACT: begin
        if (link.cke && (cmd == lpsdr_pkg::LPSDR_CMD_NOP || cmd == lpsdr_pkg::LPSDR_CMD_DESEL)) begin
          mode_next = lpsdr_pkg::LPSDR_M_NORMAL;
        end
      end
      lpsdr_pkg::LPSDR_M_DEEP: begin
        row_next = '0;
        if (link.cke) begin
          mode_next = lpsdr_pkg::LPSDR_M_NORMAL;
        end
      end
      default: mode_next = lpsdr_pkg::LPSDR_M_NORMAL;
    endcase
  end

  // mode and refresh registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= lpsdr_pkg::LPSDR_M_NORMAL;
      row_reg <= '0;
      sref_cnt_reg <= 8'h0;
      init_reg <= 1'b1;
      act_reg <= 4'h0;
      wr_bank_reg <= 2'h0;
      wr_left_reg <= 4'h0;
      wr_col_reg <= '0;
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      row_reg <= row_next;
      sref_cnt_reg <= sref_cnt_next;
      init_reg <= init_next;
      act_reg <= act_next;
      wr_bank_reg <= wr_bank_next;
      wr_left_reg <= wr_left_next;
      wr_col_reg <= wr_col_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // array store: only pairs before truncation, unmasked
  always_ff @(posedge clk_i) begin
    if (wr_en) begin
      mem[wr_bank_reg][wr_col_reg] <= link.wdata;
    end
  end
endmodule // lpsdr_dev

// ---- rtl/lpsdr_ctrl.sv ----
// Purpose: controller end: issues user commands with timing guards
// Assumes: user holds req until ack
// Notes: inserts refresh every tREFI and waits tRP/tRFC/tCKE and the exit wait
`timescale 1ns/100ps
`include "lpsdr_params.svh"
module lpsdr_ctrl #(
  parameter int AW = 13,
  parameter int DW = 16,
  parameter int DPD_CYC = `LPSDR_DPD_EXIT_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // user request
  input wire logic req_i,
  input wire logic [3:0] cmd_i,
  input wire logic cke_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [1:0] ba_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic dm_i,
  output logic ack_o,
  output logic [DW-1:0] rdata_o,
  // link
  lpsdr_if.ctrl link
);
  logic cke_reg, cke_next, ack_reg, ack_next, pend_reg, pend_next;
  logic [3:0] cmd_reg, cmd_next;
  logic [AW-1:0] addr_reg, addr_next;
  logic [1:0] ba_reg, ba_next;
  logic [DW-1:0] wd_reg, wd_next, rd_reg, rd_next;
  logic dm_reg, dm_next;
  logic [15:0] wait_reg, wait_next;
  logic [7:0] refi_reg, refi_next;
  logic start;
  assign link.cke = cke_reg;
  assign link.cmd = cmd_reg;
  assign link.addr = addr_reg;
  assign link.ba = ba_reg;
  assign link.wdata = wd_reg;
  assign link.dm = dm_reg;
  assign ack_o = ack_reg;
  assign rdata_o = rd_reg;
  assign start = (wait_reg == 16'h0) && !ack_reg;
  // issue logic
  always_comb begin
    cke_next = cke_reg;
    cmd_next = lpsdr_pkg::LPSDR_CMD_NOP;
    addr_next = addr_reg;
    ba_next = ba_reg;
    wd_next = wdata_i;
    dm_next = dm_i;
    ack_next = 1'b0;
    pend_next = pend_reg;
    rd_next = link.rvalid ? link.rdata : rd_reg;
    wait_next = (wait_reg != 16'h0) ? wait_reg - 16'h1 : 16'h0;
    refi_next = cke_reg ? refi_reg + 8'h1 : 8'h0;
    if (start && pend_reg && cke_reg) begin
      cmd_next = lpsdr_pkg::LPSDR_CMD_REF;
      pend_next = 1'b0;
      refi_next = 8'h0;
      wait_next = 16'(`LPSDR_TRFC_CYC);
    end else if (start && req_i) begin
      ack_next = 1'b1;
      cmd_next = cmd_i;
      cke_next = cke_i;
      addr_next = addr_i;
      ba_next = ba_i;
      if (!cke_i && cke_reg) begin
        wait_next = (cmd_i == lpsdr_pkg::LPSDR_CMD_REF) ? 16'(`LPSDR_TRFC_CYC) : 16'(`LPSDR_TCKE_CYC);
      end else if (cke_i && !cke_reg) begin
        cmd_next = lpsdr_pkg::LPSDR_CMD_NOP;
        wait_next = 16'(DPD_CYC);
        pend_next = 1'b1;
      end else if (cmd_i == lpsdr_pkg::LPSDR_CMD_PRE) begin
        wait_next = 16'(`LPSDR_TRP_CYC);
      end else if (cmd_i == lpsdr_pkg::LPSDR_CMD_RD || cmd_i == lpsdr_pkg::LPSDR_CMD_WR) begin
        wait_next = addr_i[`LPSDR_A10] ? 16'(`LPSDR_TWR_CYC + `LPSDR_TRP_CYC + 4) : 16'h0;
      end
    end
    // a new interval expiry outranks the clear of an older pending refresh
    if (refi_reg == 8'(`LPSDR_REFI_CYC)) begin
      pend_next = 1'b1;
    end
  end
  // registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cke_reg <= 1'b1;
      cmd_reg <= lpsdr_pkg::LPSDR_CMD_NOP;
      addr_reg <= '0;
      ba_reg <= 2'h0;
      wd_reg <= '0;
      dm_reg <= 1'b1;
      ack_reg <= 1'b0;
      pend_reg <= 1'b0;
      rd_reg <= '0;
      wait_reg <= 16'h0;
      refi_reg <= 8'h0;
    end else begin
      cke_reg <= cke_next;
      cmd_reg <= cmd_next;
      addr_reg <= addr_next;
      ba_reg <= ba_next;
      wd_reg <= wd_next;
      dm_reg <= dm_next;
      ack_reg <= ack_next;
      pend_reg <= pend_next;
      rd_reg <= rd_next;
      wait_reg <= wait_next;
      refi_reg <= refi_next;
    end
  end
endmodule // lpsdr_ctrl

// ---- verification/lpsdr_link_sva.sv ----
// Purpose: checks the command link between controller and device ends
// Assumes: one clock, tRP of 1 cycle, tRFC and tCKE of 2, exit wait of 4 cycles
// Notes: watches the interface signals only
`timescale 1ns/100ps
`include "lpsdr_params.svh"
module lpsdr_link_sva #(parameter int AW = 13, parameter int DW = 16) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // link signals
  input wire logic cke,
  input wire logic [3:0] cmd,
  input wire logic [AW-1:0] addr,
  input wire logic [1:0] ba,
  input wire logic [DW-1:0] wdata,
  input wire logic dm,
  input wire logic [DW-1:0] rdata,
  input wire logic rvalid
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [1:0] ap_ba_reg;
  logic [1:0] ap_ba_next;
  logic ap_hit;
  // remember the bank of the last auto-precharged access
  always_comb begin
    ap_ba_next = ap_ba_reg;
    if (cke && (cmd == lpsdr_pkg::LPSDR_CMD_RD || cmd == lpsdr_pkg::LPSDR_CMD_WR) && addr[10]) begin
      ap_ba_next = ba;
    end
  end
  // register only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ap_ba_reg <= 2'h0;
    end else begin
      ap_ba_reg <= ap_ba_next;
    end
  end
  // a bank command aimed at the auto-precharged bank
  assign ap_hit = cke && ba == ap_ba_reg && (cmd == lpsdr_pkg::LPSDR_CMD_ACT || cmd == lpsdr_pkg::LPSDR_CMD_RD
                  || cmd == lpsdr_pkg::LPSDR_CMD_WR || cmd == lpsdr_pkg::LPSDR_CMD_PRE);
  // command steps
  sequence s_pre;
    cke && cmd == lpsdr_pkg::LPSDR_CMD_PRE;
  endsequence
  sequence s_ap_acc;
    cke && (cmd == lpsdr_pkg::LPSDR_CMD_RD || cmd == lpsdr_pkg::LPSDR_CMD_WR) && addr[10];
  endsequence
  sequence s_sref_in;
    !cke && cmd == lpsdr_pkg::LPSDR_CMD_REF;
  endsequence
  sequence s_exit_nops;
    (cmd == lpsdr_pkg::LPSDR_CMD_NOP) [*4];
  endsequence
  sequence s_refresh;
    cke && cmd == lpsdr_pkg::LPSDR_CMD_REF;
  endsequence
  AST_PRE_TRP: assert property (s_pre |=> !(ba == $past(ba) && (cmd == lpsdr_pkg::LPSDR_CMD_ACT
    || cmd == lpsdr_pkg::LPSDR_CMD_RD || cmd == lpsdr_pkg::LPSDR_CMD_WR))) else $error("bank used inside tRP");
  AST_AP_GAP: assert property (s_ap_acc |=> !ap_hit [*7]) else $error("bank used before auto precharge done");
  AST_CMD_ONE: assert property (cmd != lpsdr_pkg::LPSDR_CMD_NOP && cmd != lpsdr_pkg::LPSDR_CMD_DESEL
    |=> cmd == lpsdr_pkg::LPSDR_CMD_NOP) else $error("command not followed by nop");
  AST_RD_DATA: assert property (rvalid |-> $past(cmd) == lpsdr_pkg::LPSDR_CMD_RD && $past(cke) ##1 !rvalid)
    else $error("read data without read");
  AST_SREF_HOLD: assert property (s_sref_in |-> ##1 (!cke && cmd == lpsdr_pkg::LPSDR_CMD_NOP))
    else $error("self refresh left early");
  AST_PD_TCKE: assert property ($fell(cke) |-> !cke [*2]) else $error("power-down shorter than tCKE");
  AST_EXIT_SEQ: assert property ($rose(cke) |-> s_exit_nops ##[1:20] s_refresh)
    else $error("exit not followed by nops and refresh");
  AST_LOW_QUIET: assert property (!cke && !$past(cke) |-> cmd == lpsdr_pkg::LPSDR_CMD_NOP
    || cmd == lpsdr_pkg::LPSDR_CMD_DESEL) else $error("command sent while cke low");
endmodule // lpsdr_link_sva

// ---- verification/sdram_precharge_refresh_power_test.sv ----
// Purpose: drives the controller user side and judges both ends
// Assumes: exit wait shortened to 4 cycles, refresh every 78 cycles
// Notes: inputs change on the falling edge only
`timescale 1ns/100ps
module sdram_precharge_refresh_power_test;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_i = 1'b0;
  logic [3:0] cmd_i = 4'h7;
  logic cke_i = 1'b1;
  logic [12:0] addr_i = 13'h0000;
  logic [1:0] ba_i = 2'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic dm_i = 1'b0;
  logic ack_o;
  logic [15:0] rdata_o;
  lpsdr_pkg::lpsdr_mode_t mode;
  logic [12:0] ref_row;
  logic [3:0] bank_act;
  logic need_init;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int ref_cnt = 0;
  int rd_cnt = 0;
  lpsdr_if u_lpsdr_if ();
  lpsdr_ctrl #(.DPD_CYC(4)) u_lpsdr_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
    .cmd_i(cmd_i), .cke_i(cke_i), .addr_i(addr_i), .ba_i(ba_i), .wdata_i(wdata_i), .dm_i(dm_i), .ack_o(ack_o),
    .rdata_o(rdata_o), .link(u_lpsdr_if));
  lpsdr_dev u_lpsdr_dev (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .link(u_lpsdr_if), .mode_o(mode), .ref_row_o(ref_row), .bank_active_o(bank_act), .need_init_o(need_init));
  lpsdr_link_sva u_lpsdr_link_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .cke(u_lpsdr_if.cke),
    .cmd(u_lpsdr_if.cmd), .addr(u_lpsdr_if.addr), .ba(u_lpsdr_if.ba), .wdata(u_lpsdr_if.wdata), .dm(u_lpsdr_if.dm),
    .rdata(u_lpsdr_if.rdata), .rvalid(u_lpsdr_if.rvalid));
  // 10 MHz clock
  always #50 clk_i = ~clk_i;
  // link monitors and hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (u_lpsdr_if.cke === 1'b1 && u_lpsdr_if.cmd === 4'h1) ref_cnt++;
    if (u_lpsdr_if.rvalid === 1'b1) rd_cnt++;
    if (cycles == 6000) begin
      miscompares++;
      results();
    end
  end
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // one user request held until ack
  task automatic issue(input logic [3:0] c, input logic k, input logic [12:0] a, input logic [1:0] b,
                       input logic [15:0] d, input logic m);
    int n = 0;
    req_i = 1'b1;
    cmd_i = c;
    cke_i = k;
    addr_i = a;
    ba_i = b;
    wdata_i = d;
    dm_i = m;
    do begin
      @(negedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 300);
    check("ack", 16'h0001, 16'(ack_o));
    req_i = 1'b0;
    idle(2);
  endtask
  task automatic t_reset;
    idle(10);
    check("reset cke", 16'h0001, 16'(u_lpsdr_if.cke));
    check("reset cmd", 16'h0007, 16'(u_lpsdr_if.cmd));
    check("reset dm", 16'h0001, 16'(u_lpsdr_if.dm));
    rst_n_i = 1'b1;
    idle(1);
    check("mode", 16'(lpsdr_pkg::LPSDR_M_NORMAL), 16'(mode));
    check("banks", 16'h0000, 16'(bank_act));
    check("need init", 16'h0001, 16'(need_init));
    issue(4'h0, 1'b1, 13'h0000, 2'h0, 16'h0000, 1'b0);
    check("need init", 16'h0000, 16'(need_init));
    $display("done: reset");
  endtask
  task automatic t_precharge;
    issue(4'h3, 1'b1, 13'h0011, 2'h0, 16'h0000, 1'b0);
    issue(4'h3, 1'b1, 13'h0022, 2'h2, 16'h0000, 1'b0);
    check("banks", 16'h0005, 16'(bank_act));
    issue(4'h2, 1'b1, 13'h0000, 2'h0, 16'h0000, 1'b0);
    check("banks", 16'h0004, 16'(bank_act));
    issue(4'h2, 1'b1, 13'h0000, 2'h0, 16'h0000, 1'b0);
    check("banks", 16'h0004, 16'(bank_act));
    issue(4'h3, 1'b1, 13'h0033, 2'h1, 16'h0000, 1'b0);
    issue(4'h2, 1'b1, 13'h0400, 2'h1, 16'h0000, 1'b0);
    check("banks", 16'h0000, 16'(bank_act));
    $display("done: precharge");
  endtask
  task automatic t_access;
    int r0 = rd_cnt;
    issue(4'h5, 1'b1, 13'h0008, 2'h3, 16'h0000, 1'b0);
    idle(3);
    check("read on idle bank", 16'(r0), 16'(rd_cnt));
    issue(4'h3, 1'b1, 13'h0044, 2'h3, 16'h0000, 1'b0);
    issue(4'h4, 1'b1, 13'h0008, 2'h3, 16'h1234, 1'b0);
    issue(4'h4, 1'b1, 13'h0008, 2'h3, 16'hFFFF, 1'b1);
    issue(4'h5, 1'b1, 13'h0008, 2'h3, 16'h0000, 1'b0);
    idle(2);
    check("read count", 16'(r0 + 1), 16'(rd_cnt));
    check("masked word", 16'h1234, rdata_o);
    check("banks", 16'h0008, 16'(bank_act));
    issue(4'h5, 1'b1, 13'h0408, 2'h3, 16'h0000, 1'b0);
    idle(12);
    check("banks", 16'h0000, 16'(bank_act));
    $display("done: access");
  endtask
  // write cut by precharge: pairs after the cut must not land
  task automatic t_truncate;
    int c0 = ref_cnt;
    // start just after a refresh so none slips into the burst
    for (int i = 0; i < 200 && ref_cnt == c0; i++) @(negedge clk_i);
    issue(4'h3, 1'b1, 13'h0066, 2'h2, 16'h0000, 1'b0);
    issue(4'h4, 1'b1, 13'h0000, 2'h2, 16'h5555, 1'b0);
    idle(4);
    issue(4'h4, 1'b1, 13'h0000, 2'h2, 16'h1111, 1'b0);
    issue(4'h2, 1'b1, 13'h0000, 2'h2, 16'h2222, 1'b0);
    issue(4'h3, 1'b1, 13'h0066, 2'h2, 16'h2222, 1'b0);
    issue(4'h5, 1'b1, 13'h0001, 2'h2, 16'h2222, 1'b0);
    check("kept pair", 16'h1111, rdata_o);
    issue(4'h5, 1'b1, 13'h0002, 2'h2, 16'h2222, 1'b0);
    check("cut pair", 16'h5555, rdata_o);
    issue(4'h2, 1'b1, 13'h0000, 2'h2, 16'h2222, 1'b0);
    check("banks", 16'h0000, 16'(bank_act));
    $display("done: truncate");
  endtask
  task automatic t_refresh;
    int c0 = ref_cnt;
    logic [12:0] w0 = ref_row;
    idle(170);
    check("refresh issued", 16'h0001, 16'(ref_cnt - c0 >= 2));
    check("refresh row", 16'(ref_cnt - c0), 16'(ref_row - w0));
    $display("done: refresh");
  endtask
  task automatic t_power_down;
    issue(4'h3, 1'b1, 13'h0055, 2'h0, 16'h0000, 1'b0);
    issue(4'h7, 1'b0, 13'h0000, 2'h0, 16'h0000, 1'b0);
    check("mode", 16'(lpsdr_pkg::LPSDR_M_PD_ACT), 16'(mode));
    issue(4'h7, 1'b1, 13'h0000, 2'h0, 16'h0000, 1'b0);
    idle(8);
    check("mode", 16'(lpsdr_pkg::LPSDR_M_NORMAL), 16'(mode));
    issue(4'h2, 1'b1, 13'h0400, 2'h0, 16'h0000, 1'b0);
    issue(4'h7, 1'b0, 13'h0000, 2'h0, 16'h0000, 1'b0);
    check("mode", 16'(lpsdr_pkg::LPSDR_M_PD_PRE), 16'(mode));
    issue(4'h7, 1'b1, 13'h0000, 2'h0, 16'h0000, 1'b0);
    idle(8);
    check("mode", 16'(lpsdr_pkg::LPSDR_M_NORMAL), 16'(mode));
    $display("done: power down");
  endtask
  task automatic t_self_refresh;
    logic [12:0] w0;
    issue(4'h1, 1'b0, 13'h0000, 2'h0, 16'h0000, 1'b0);
    check("mode", 16'(lpsdr_pkg::LPSDR_M_SELF_REF), 16'(mode));
    w0 = ref_row;
    idle(170);
    check("internal refresh", 16'h0001, 16'(ref_row - w0 >= 2 && ref_row - w0 <= 3));
    issue(4'h7, 1'b1, 13'h0000, 2'h0, 16'h0000, 1'b0);
    idle(8);
    check("mode", 16'(lpsdr_pkg::LPSDR_M_NORMAL), 16'(mode));
    $display("done: self refresh");
  endtask
  task automatic t_deep;
    issue(4'h6, 1'b0, 13'h0000, 2'h0, 16'h0000, 1'b0);
    check("mode", 16'(lpsdr_pkg::LPSDR_M_DEEP), 16'(mode));
    check("need init", 16'h0001, 16'(need_init));
    idle(5);
    issue(4'h7, 1'b1, 13'h0000, 2'h0, 16'h0000, 1'b0);
    idle(8);
    check("mode", 16'(lpsdr_pkg::LPSDR_M_NORMAL), 16'(mode));
    issue(4'h0, 1'b1, 13'h0000, 2'h0, 16'h0000, 1'b0);
    check("need init", 16'h0000, 16'(need_init));
    $display("done: deep power down");
  endtask
  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // main sequence, reset held for 20 cycles
  initial begin
    idle(10);
    t_reset();
    t_precharge();
    t_access();
    t_truncate();
    t_refresh();
    t_power_down();
    t_self_refresh();
    t_deep();
    results();
  end
endmodule // sdram_precharge_refresh_power_test
